// ===== osc_cal_pkg.sv
package osc_cal_pkg;
  // register offsets (8-bit register address space)
  localparam logic [7:0] PLL_OVERRIDE_ADDR = 8'h58;
  localparam logic [7:0] OSC_TRIM_ADDR = 8'h59;
  localparam logic [7:0] PLL_CAL_RESET_ADDR = 8'h5C;
  localparam logic [7:0] OSC_CAL_CONTROL_ADDR = 8'h5D;
  localparam logic [7:0] OSC_CAL_STATUS_ADDR = 8'h5E;
  // reset values
  localparam logic [7:0] PLL_OVERRIDE_RST = 8'h00;
  localparam logic [7:0] PLL_CAL_RESET_RST = 8'h00;
  localparam logic [7:0] OSC_CAL_CONTROL_RST = 8'h40;
  localparam logic [6:0] OSC_TRIM_RST = 7'h00;
  // field positions
  localparam int PLL_CAL_RESET_BIT = 0;
  localparam int CAL_ENABLE_BIT = 0;
  localparam int SETTLE_LSB = 4;
  localparam int SETTLE_MSB = 6;
  localparam int DONE_BIT = 0;
  localparam int OVR_ENABLE_BIT = 7;
  localparam int OVR_PLL_EN_BIT = 0;
  localparam int TRIM_MSB = 6;
  // settling base time per step, scaled by 2**settle_time_select
  localparam int SETTLE_BASE_NS = 64;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SETTLE_BASE_CYC = (SETTLE_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIM_W = 7;
  localparam int SETTLE_W = 3;
  localparam int SETTLE_CNT_W = 16;
  // engine states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_STEP   = 5'b00010,
    ST_SETTLE = 5'b00100,
    ST_EVAL   = 5'b01000,
    ST_DONE   = 5'b10000
  } cal_state_t;
endpackage

// ===== settle_timer.sv
`timescale 1ns/100ps
module settle_timer
  import osc_cal_pkg::*;
#(
  parameter int CNT_W = SETTLE_CNT_W,
  parameter int BASE_CYC = SETTLE_BASE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [SETTLE_W-1:0] select,
  output logic expired
);
  initial begin
    if (BASE_CYC < 1 || CNT_W < SETTLE_W + 8) $error("settle_timer: bad parameters");
  end
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic run;
    logic expired;
  } tmr_t;
  tmr_t st_reg, st_next;
  // wait length doubles with each select step
  function automatic logic [CNT_W-1:0] wait_len(input logic [SETTLE_W-1:0] sel);
    wait_len = CNT_W'(BASE_CYC) << sel;
  endfunction
  // count down from one below the wait length, pulse expired at zero
  always_comb begin
    st_next = st_reg;
    st_next.expired = 1'b0;
    if (start) begin
      st_next.cnt = wait_len(select) - CNT_W'(1);
      st_next.run = 1'b1;
    end else if (st_reg.run) begin
      if (st_reg.cnt == '0) begin
        st_next.run = 1'b0;
        st_next.expired = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt - CNT_W'(1);
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign expired = st_reg.expired;
endmodule // settle_timer

// ===== pll_osc_trim_calibration.sv
`timescale 1ns/100ps
module pll_osc_trim_calibration
  import osc_cal_pkg::*;
#(
  parameter int CNT_W = SETTLE_CNT_W
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic pll_enable_pin,
  input wire logic osc_too_fast,
  output logic pll_enable,
  output logic pll_cal_hold,
  output logic [TRIM_W-1:0] osc_trim_code,
  output logic osc_cal_busy
);
  initial begin
    if (CNT_W < SETTLE_W + 8) $error("pll_osc_trim_calibration: CNT_W too small");
  end
  typedef struct packed {
    cal_state_t state;
    logic [7:0] ovr;
    logic cal_reset;
    logic [7:0] ctrl;
    logic [TRIM_W-1:0] trim;
    logic [TRIM_W-1:0] step_bit;
    logic done;
    logic [7:0] rdata;
    logic fast_s1;
    logic fast_s2;
    logic pin_s1;
    logic pin_s2;
  } state_t;
  state_t s_reg, s_next;
  logic settle_start;
  logic settle_done;
  logic cal_enable;
  logic [SETTLE_W-1:0] settle_time_select;
  assign cal_enable = s_reg.ctrl[CAL_ENABLE_BIT];
  assign settle_time_select = s_reg.ctrl[SETTLE_MSB:SETTLE_LSB];
  // per-step settle wait; length grows with the select field
  settle_timer #(
    .CNT_W(CNT_W),
    .BASE_CYC(SETTLE_BASE_CYC)
  ) u_settle (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .start(settle_start),
    .select(settle_time_select),
    .expired(settle_done)
  );
  // register file, read mux and successive-approximation engine
  always_comb begin
    s_next = s_reg;
    settle_start = 1'b0;
    s_next.fast_s1 = osc_too_fast;
    s_next.fast_s2 = s_reg.fast_s1;
    s_next.pin_s1 = pll_enable_pin;
    s_next.pin_s2 = s_reg.pin_s1;
    // register writes; reserved bits of override and control read back as written, those of cal reset and trim read zero
    if (reg_wr) begin
      case (reg_addr)
        PLL_OVERRIDE_ADDR: s_next.ovr = reg_wdata;
        PLL_CAL_RESET_ADDR: s_next.cal_reset = reg_wdata[PLL_CAL_RESET_BIT];
        OSC_CAL_CONTROL_ADDR: s_next.ctrl = reg_wdata;
        OSC_TRIM_ADDR: s_next.trim = reg_wdata[TRIM_MSB:0];
        default: ;
      endcase
    end
    // engine sequence
    case (s_reg.state)
      ST_IDLE: begin
        // leaving reset starts a run or reports skip
        if (!s_reg.cal_reset) begin
          if (cal_enable) begin
            s_next.trim = OSC_TRIM_RST | TRIM_W'(1) << (TRIM_W - 1);
            s_next.step_bit = TRIM_W'(1) << (TRIM_W - 1);
            settle_start = 1'b1;
            s_next.state = ST_SETTLE;
          end else begin
            s_next.done = 1'b1;
            s_next.state = ST_DONE;
          end
        end
      end
      ST_STEP: begin
        // apply the next trial bit and settle again
        s_next.trim = s_reg.trim | s_reg.step_bit;
        settle_start = 1'b1;
        s_next.state = ST_SETTLE;
      end
      ST_SETTLE: begin
        if (settle_done) begin
          s_next.state = ST_EVAL;
        end
      end
      ST_EVAL: begin
        // too fast: drop the trial bit to centre the frequency
        if (s_reg.fast_s2) begin
          s_next.trim = s_reg.trim & ~s_reg.step_bit;
        end
        s_next.step_bit = s_reg.step_bit >> 1;
        if (s_reg.step_bit[0]) begin
          s_next.done = 1'b1;
          s_next.state = ST_DONE;
        end else begin
          s_next.state = ST_STEP;
        end
      end
      ST_DONE: ;
      default: s_next.state = ST_IDLE;
    endcase
    // calibration reset aborts a run and clears done
    if (s_reg.cal_reset) begin
      s_next.done = 1'b0;
      if (s_reg.state != ST_IDLE) begin
        s_next.state = ST_IDLE;
      end
    end
    // registered read data; status is read-only
    s_next.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        PLL_OVERRIDE_ADDR: s_next.rdata = s_reg.ovr;
        OSC_TRIM_ADDR: s_next.rdata = {1'b0, s_reg.trim};
        PLL_CAL_RESET_ADDR: s_next.rdata = {7'h00, s_reg.cal_reset};
        OSC_CAL_CONTROL_ADDR: s_next.rdata = s_reg.ctrl;
        OSC_CAL_STATUS_ADDR: s_next.rdata = {7'h00, s_reg.done};
        default: s_next.rdata = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.state <= ST_IDLE;
      s_reg.ovr <= PLL_OVERRIDE_RST;
      s_reg.cal_reset <= PLL_CAL_RESET_RST[PLL_CAL_RESET_BIT];
      s_reg.ctrl <= OSC_CAL_CONTROL_RST;
      s_reg.trim <= OSC_TRIM_RST;
    end else begin
      s_reg <= s_next;
    end
  end
  // pll enable from override bit or synchronised pin
  assign pll_enable = s_reg.ovr[OVR_ENABLE_BIT] ? s_reg.ovr[OVR_PLL_EN_BIT] : s_reg.pin_s2;
  assign pll_cal_hold = s_reg.cal_reset;
  assign osc_trim_code = s_reg.trim;
  assign osc_cal_busy = (s_reg.state != ST_IDLE) && (s_reg.state != ST_DONE);
  assign reg_rdata = s_reg.rdata;
endmodule // pll_osc_trim_calibration

// ===== osc_cal_assertions.sv
`timescale 1ns/100ps
module osc_cal_assertions
  import osc_cal_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic pll_cal_hold,
  input wire logic [TRIM_W-1:0] osc_trim_code,
  input wire logic osc_cal_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // a run begins when the engine leaves idle
  sequence run_start;
    $rose(osc_cal_busy);
  endsequence
  idle_rdata_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  hold_write_a: assert property (reg_wr && reg_addr == PLL_CAL_RESET_ADDR
    |=> pll_cal_hold == $past(reg_wdata[0])) else $error("hold bit wrong");
  abort_run_a: assert property (pll_cal_hold [*2] |-> !osc_cal_busy)
    else $error("busy under hold");
  msb_first_a: assert property (run_start |-> osc_trim_code == 7'h40)
    else $error("first trial wrong");
  settle_min_a: assert property (run_start |-> osc_cal_busy [*8])
    else $error("settle too short");
  trim_hold_a: assert property (!osc_cal_busy && !(reg_wr && reg_addr == OSC_TRIM_ADDR)
    |=> osc_cal_busy || $stable(osc_trim_code)) else $error("trim moved");
  trim_read_a: assert property (reg_rd && reg_addr == OSC_TRIM_ADDR
    |=> reg_rdata == {1'b0, $past(osc_trim_code)}) else $error("trim read");
  status_res_a: assert property (reg_rd && reg_addr == OSC_CAL_STATUS_ADDR
    |=> reg_rdata[7:1] == 7'h00) else $error("status reserved");
  done_busy_a: assert property (reg_rd && reg_addr == OSC_CAL_STATUS_ADDR && osc_cal_busy
    |=> !reg_rdata[0]) else $error("done while busy");
endmodule // osc_cal_assertions
bind pll_osc_trim_calibration osc_cal_assertions osc_cal_assertions_i (.clk_sys, .rst_b,
  .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .pll_cal_hold, .osc_trim_code,
  .osc_cal_busy);

// ===== tb_top.sv
`timescale 1ns/100ps
module tb_top
  import osc_cal_pkg::*;
;
  logic clk_sys, rst_b, reg_wr, reg_rd, pll_enable_pin, osc_too_fast;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic pll_enable, pll_cal_hold, osc_cal_busy;
  logic [TRIM_W-1:0] osc_trim_code;
  int miscompares = 0, checks = 0, n0, n1;
  localparam logic [6:0] TARGET = 7'h35;
  // rows: write flag, address, write data, expected read
  logic [24:0] rows [11] = '{25'h05C_00_00, 25'h05D_00_40, 25'h05E_00_01, 25'h059_00_00,
    25'h058_00_00, 25'h15C_01_01, 25'h15D_01_01, 25'h15E_FF_00, 25'h159_2A_2A,
    25'h158_81_81, 25'h130_55_00};
  pll_osc_trim_calibration #(.CNT_W(16)) pll_osc_trim_calibration_i (.clk_sys, .rst_b,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .pll_enable_pin, .osc_too_fast,
    .pll_enable, .pll_cal_hold, .osc_trim_code, .osc_cal_busy);
  // oscillator comparator: too fast above the target trim
  always @(negedge clk_sys) osc_too_fast <= osc_trim_code > TARGET;
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk_sys) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk_sys) reg_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(negedge clk_sys) {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk_sys) reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask
  // one run with the given control value, n counts busy cycles
  task automatic run(logic [7:0] ctrl, output int n);
    wr(PLL_CAL_RESET_ADDR, 8'h01);
    wr(OSC_CAL_CONTROL_ADDR, ctrl);
    wr(PLL_CAL_RESET_ADDR, 8'h00);
    n = 0;
    for (int i = 0; i < 3000 && !(n > 0 && !osc_cal_busy); i++) begin
      @(negedge clk_sys) n += osc_cal_busy;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // watchdog well beyond the expected run time
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    {rst_b, reg_wr, reg_rd, pll_enable_pin, osc_too_fast, reg_addr, reg_wdata} = '0;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys) rst_b = 1'b1;
    repeat (2) @(negedge clk_sys);
    foreach (rows[i]) begin
      if (rows[i][24]) wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    chk({7'h00, pll_enable}, 8'h01);
    $display("register test done");
    run(8'h01, n0);
    rd(OSC_CAL_STATUS_ADDR, 8'h01);
    rd(OSC_TRIM_ADDR, {1'b0, TARGET});
    run(8'h11, n1);
    chk(8'(n1 > n0), 8'h01);
    wr(OSC_TRIM_ADDR, 8'h2A);
    $display("calibration test done");
    run(8'h00, n0);
    chk(8'(n0), 8'h00);
    rd(OSC_CAL_STATUS_ADDR, 8'h01);
    rd(OSC_TRIM_ADDR, 8'h2A);
    $display("skip test done");
    wr(PLL_CAL_RESET_ADDR, 8'h01);
    wr(OSC_CAL_CONTROL_ADDR, 8'h01);
    wr(PLL_CAL_RESET_ADDR, 8'h00);
    repeat (18) @(negedge clk_sys);
    rd(OSC_CAL_STATUS_ADDR, 8'h00);
    chk({7'h00, osc_cal_busy}, 8'h01);
    wr(PLL_CAL_RESET_ADDR, 8'h01);
    // engine drops to idle one edge after the hold bit is stored
    @(negedge clk_sys);
    chk({7'h00, osc_cal_busy}, 8'h00);
    rd(OSC_CAL_STATUS_ADDR, 8'h00);
    $display("abort test done");
    // pin path: override off, pin passes two sync stages
    wr(PLL_OVERRIDE_ADDR, 8'h00);
    pll_enable_pin = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk({7'h00, pll_enable}, 8'h01);
    pll_enable_pin = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk({7'h00, pll_enable}, 8'h00);
    $display("pin test done");
    report_and_stop();
  end
endmodule // tb_top
